// *** rtl/ebc_bus_ctrl.sv ***
// External multiplexed bus controller with hold and wait handling.
// Assumes a 10 MHz clk, synchronous active-low rstn, and a core that
// holds cpu_req with stable fields until cpu_done pulses.
//
// Overview of operation
// - Byte-high enable low for odd addresses.
// - Address latch strobe marks address phase only.
// - Float the shared pins, then drive grant low.
// - Stay held while bus request is low.
// - Wait input low stretches the data phase.
// - System clock driven out on a pin.
// - Access strobe low during reads and writes.
// - Read/write high for read, low write.
// - Shared pins carry address, then data; in narrow mode the mid pins keep the address.
`timescale 1ns/1ps
`include "ebc_consts.svh"

module ebc_bus_ctrl
(
  input  wire logic                   clk,
  input  wire logic                   rstn,
  input  wire logic                   cpu_req,
  input  wire logic                   cpu_wr,
  input  wire logic [`EBC_ADDR_W-1:0] cpu_addr,
  input  wire logic [`EBC_DATA_W-1:0] cpu_wdata,
  output logic      [`EBC_DATA_W-1:0] cpu_rdata,
  output logic                        cpu_done,
  input  wire logic                   bus_width_sel,
  input  wire logic                   hold_req_n,
  input  wire logic                   ready_n,
  output logic      [`EBC_BYTE_W-1:0] addr_low_out,
  input  wire logic [`EBC_BYTE_W-1:0] ad_mid_in,
  output logic      [`EBC_BYTE_W-1:0] ad_mid_out,
  output logic                        ad_mid_oe,
  input  wire logic [`EBC_BYTE_W-1:0] ad_high_in,
  output logic      [`EBC_BYTE_W-1:0] ad_high_out,
  output logic                        ad_high_oe,
  output logic                        addr_latch_out,
  output logic                        access_strobe_n,
  output logic                        rw_out,
  output logic                        byte_high_enable_n,
  output logic                        bus_grant_out_n,
  output logic                        sys_clk_out
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [`EBC_SYNC_W-1:0] sync_q;
  logic                   byte_s;
  logic                   hold_s;
  logic                   ready_s;
  logic [`EBC_BYTE_W-1:0] mid_s;
  logic [`EBC_BYTE_W-1:0] high_s;
  logic                   ph_en;

  ebc_sync #(.WIDTH(`EBC_SYNC_W)) u_sync
  (
    .clk  (clk),
    .rstn (rstn),
    .din  ({bus_width_sel, hold_req_n, ready_n, ad_mid_in, ad_high_in}),
    .dout (sync_q)
  );

  // Synchronised levels; the data pins lag two cycles, so read data
  // is taken one phase after the data phase ends.
  assign {byte_s, hold_s, ready_s, mid_s, high_s} = sync_q;

  // ----------------------------------------------------------------
  // State and next state
  // ----------------------------------------------------------------
  ebc_pkg::ebc_regs_t r_reg;
  ebc_pkg::ebc_regs_t r_next;

  // One bus phase is one period of the output clock.
  assign ph_en = (r_reg.div == 2'(`EBC_PHASE_CYC - 1));

  // Sequencer: address phase, data phase, turnaround, or hold.
  always_comb
  begin
    r_next      = r_reg;
    r_next.done = 1'b0;
    r_next.div     = ph_en ? 2'h0 : 2'(r_reg.div + 2'h1);
    r_next.clk_out = (r_next.div == 2'h0);
    case (r_reg.st)
      ebc_pkg::EBC_IDLE:
      begin
        if (ph_en && !hold_s)
        begin
          r_next.st      = ebc_pkg::EBC_FLOAT;
          r_next.mid_oe  = 1'b0;
          r_next.high_oe = 1'b0;
        end
        else if (ph_en && cpu_req)
        begin
          r_next.st      = ebc_pkg::EBC_ADDR;
          r_next.wr      = cpu_wr;
          r_next.addr    = cpu_addr;
          r_next.wdata   = cpu_wdata;
          r_next.wide    = !byte_s;
          r_next.ale     = 1'b1;
          r_next.mid_o   = cpu_addr[15:8];
          r_next.high_o  = cpu_addr[23:16];
          r_next.mid_oe  = 1'b1;
          r_next.high_oe = 1'b1;
          r_next.rw      = !cpu_wr;
          r_next.bhe_n   = !cpu_addr[`EBC_ODD_BIT];
        end
      end
      ebc_pkg::EBC_ADDR:
      begin
        if (ph_en)
        begin
          r_next.st       = ebc_pkg::EBC_DATA;
          r_next.ale      = 1'b0;
          r_next.strobe_n = 1'b0;
          if (r_reg.wr)
          begin
            r_next.high_o = r_reg.wdata[7:0];
            if (r_reg.wide)
            begin
              r_next.mid_o = r_reg.wdata[15:8];
            end
          end
          else
          begin
            r_next.high_oe = 1'b0;
            r_next.mid_oe  = !r_reg.wide;
          end
        end
      end
      ebc_pkg::EBC_DATA:
      begin
        if (ph_en && ready_s)
        begin
          r_next.st       = ebc_pkg::EBC_DONE;
          r_next.strobe_n = 1'b1;
        end
      end
      ebc_pkg::EBC_DONE:
      begin
        // Turnaround phase keeps a write's data from meeting a
        // device that starts driving on the next read. The synchronised
        // pins now show the last strobe-low cycle, so reads land here.
        if (ph_en)
        begin
          r_next.st      = ebc_pkg::EBC_IDLE;
          r_next.done    = 1'b1;
          r_next.mid_oe  = 1'b0;
          r_next.high_oe = 1'b0;
          r_next.rw      = `EBC_RW_RST;
          r_next.bhe_n   = `EBC_BHE_RST;
          if (!r_reg.wr)
          begin
            r_next.rdata = r_reg.wide ? {mid_s, high_s}
                                      : {`EBC_BYTE_ZERO, high_s};
          end
        end
      end
      ebc_pkg::EBC_FLOAT:
      begin
        if (ph_en)
        begin
          r_next.st      = ebc_pkg::EBC_HOLD;
          r_next.grant_n = 1'b0;
        end
      end
      ebc_pkg::EBC_HOLD:
      begin
        if (ph_en && hold_s)
        begin
          r_next.st      = ebc_pkg::EBC_IDLE;
          r_next.grant_n = `EBC_GRANT_RST;
        end
      end
      default:
      begin
        r_next.st = ebc_pkg::EBC_IDLE;
      end
    endcase
  end

  // Register the whole state; reset puts every strobe inactive.
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      r_reg          <= '0;
      r_reg.strobe_n <= `EBC_STROBE_RST;
      r_reg.rw       <= `EBC_RW_RST;
      r_reg.bhe_n    <= `EBC_BHE_RST;
      r_reg.grant_n  <= `EBC_GRANT_RST;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  // Outputs straight from the state flip-flops.
  assign cpu_rdata          = r_reg.rdata;
  assign cpu_done           = r_reg.done;
  assign addr_low_out       = r_reg.addr[7:0];
  assign ad_mid_out         = r_reg.mid_o;
  assign ad_mid_oe          = r_reg.mid_oe;
  assign ad_high_out        = r_reg.high_o;
  assign ad_high_oe         = r_reg.high_oe;
  assign addr_latch_out     = r_reg.ale;
  assign access_strobe_n    = r_reg.strobe_n;
  assign rw_out             = r_reg.rw;
  assign byte_high_enable_n = r_reg.bhe_n;
  assign bus_grant_out_n    = r_reg.grant_n;
  assign sys_clk_out        = r_reg.clk_out;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_addr_phase;
    r_reg.ale [*2];
  endsequence

  sequence s_data_start;
    !r_reg.strobe_n && !r_reg.ale;
  endsequence

  a_bhe_odd: assert property (
    (r_reg.st == ebc_pkg::EBC_DATA)
      |-> (r_reg.bhe_n == !r_reg.addr[`EBC_ODD_BIT]))
    else $error("Byte-high enable wrong for access parity.");

  a_ale_phase: assert property (
    $rose(r_reg.ale) |-> r_reg.mid_oe && r_reg.high_oe
      && (r_reg.high_o == r_reg.addr[23:16])
      ##0 s_addr_phase ##1 s_data_start)
    else $error("Latch strobe not two cycles before data phase.");

  a_grant_after_float: assert property (
    $fell(r_reg.grant_n) |-> !r_reg.mid_oe && !r_reg.high_oe
      && ($past(r_reg.st) == ebc_pkg::EBC_FLOAT))
    else $error("Grant given without floating the bus.");

  a_hold_stays: assert property (
    (r_reg.st == ebc_pkg::EBC_HOLD) && !hold_s
      |=> (r_reg.st == ebc_pkg::EBC_HOLD) && !r_reg.grant_n)
    else $error("Hold left while request still low.");

  a_wait_stretch: assert property (
    (r_reg.st == ebc_pkg::EBC_DATA) && !ready_s
      |=> (r_reg.st == ebc_pkg::EBC_DATA) && !r_reg.strobe_n)
    else $error("Data phase ended during wait.");

  a_clk_period: assert property (
    $rose(r_reg.clk_out) |=> !r_reg.clk_out ##1 r_reg.clk_out)
    else $error("Clock output period wrong.");

  a_strobe_data: assert property (
    !r_reg.strobe_n |-> (r_reg.st == ebc_pkg::EBC_DATA))
    else $error("Access strobe low outside data phase.");

  a_rw_dir: assert property (
    (r_reg.st == ebc_pkg::EBC_DATA) |-> (r_reg.rw == !r_reg.wr))
    else $error("Read/write level does not match access.");

  a_mux_data: assert property (
    (r_reg.st == ebc_pkg::EBC_DATA) && r_reg.wr && r_reg.wide
      |-> (r_reg.mid_o == r_reg.wdata[15:8])
      && (r_reg.high_o == r_reg.wdata[7:0]))
    else $error("Write data not on shared pins.");

  a_grant_release: assert property (
    $rose(r_reg.grant_n) |-> $past(hold_s)
      && ($past(r_reg.st) == ebc_pkg::EBC_HOLD))
    else $error("Grant released while request low.");

endmodule

// *** rtl/ebc_consts.svh ***
// Constants for the external bus control block.
// Assumes inclusion by bare name from the rtl folder.
`ifndef EBC_CONSTS_SVH
`define EBC_CONSTS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define EBC_CLK_NS      100
`define EBC_PHASE_NS    200
`define EBC_PHASE_CYC   (`EBC_PHASE_NS / `EBC_CLK_NS)

// ----------------------------------------------------------------
// Widths and field positions
// ----------------------------------------------------------------
`define EBC_ADDR_W      24
`define EBC_DATA_W      16
`define EBC_BYTE_W      8
`define EBC_SYNC_W      19
`define EBC_ODD_BIT     0

// ----------------------------------------------------------------
// Reset values of the pin-facing controls
// ----------------------------------------------------------------
`define EBC_STROBE_RST  1'b1
`define EBC_RW_RST      1'b1
`define EBC_BHE_RST     1'b1
`define EBC_GRANT_RST   1'b1
`define EBC_BYTE_ZERO   8'h00

`endif

// *** rtl/ebc_pkg.sv ***
// Types shared by the external bus control block.
// Assumes the constants header sits beside it.
`include "ebc_consts.svh"

package ebc_pkg;

  // ----------------------------------------------------------------
  // Bus sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0]
  {
    EBC_IDLE,
    EBC_ADDR,
    EBC_DATA,
    EBC_DONE,
    EBC_FLOAT,
    EBC_HOLD
  } ebc_state_t;

  // ----------------------------------------------------------------
  // Whole state of the controller
  // ----------------------------------------------------------------
  typedef struct packed
  {
    ebc_state_t                 st;
    logic [1:0]                 div;
    logic                       clk_out;
    logic                       wr;
    logic                       wide;
    logic [`EBC_ADDR_W-1:0]     addr;
    logic [`EBC_DATA_W-1:0]     wdata;
    logic [`EBC_DATA_W-1:0]     rdata;
    logic [`EBC_BYTE_W-1:0]     mid_o;
    logic [`EBC_BYTE_W-1:0]     high_o;
    logic                       mid_oe;
    logic                       high_oe;
    logic                       ale;
    logic                       strobe_n;
    logic                       rw;
    logic                       bhe_n;
    logic                       grant_n;
    logic                       done;
  } ebc_regs_t;

endpackage

// *** rtl/ebc_sync.sv ***
// Two-stage synchroniser for pin inputs.
// Assumes every bit is an independent level from outside the clock.
`timescale 1ns/1ps
`include "ebc_consts.svh"

module ebc_sync
#(
  parameter int WIDTH = `EBC_SYNC_W
)
(
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_reg;

  // The first stage feeds only the second; nothing else looks at it.
  // Both stages keep sampling during reset, so they hold the real pin
  // levels when it ends; a constant here would fake a hold request.
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      meta_reg <= din;
      dout     <= meta_reg;
    end
    else
    begin
      meta_reg <= din;
      dout     <= meta_reg;
    end
  end

endmodule

// *** tb/ebc_bus_ctrl_bench.sv ***
// Self-checking bench for the external bus controller.
// Assumes the rtl folder is on the include path.
`timescale 1ns/1ps
`include "ebc_consts.svh"

module ebc_bus_ctrl_bench;
  logic        clk      = 1'b0;
  logic        rstn     = 1'b0;
  logic        cpu_req  = 1'b0;
  logic        cpu_wr   = 1'b0;
  logic [23:0] cpu_addr = 24'h0;
  logic [15:0] cpu_wd   = 16'h0;
  logic        narrow   = 1'b0;
  logic        hold_n   = 1'b1;
  logic        slow     = 1'b0;
  logic [15:0] rdata;
  logic        done;
  logic        rdy_n;
  logic        ale;
  logic        stb_n;
  logic        rw;
  logic        bhe_n;
  logic        gnt_n;
  logic        sclk;
  logic        mid_oe;
  logic        high_oe;
  logic [7:0]  a_low;
  logic [7:0]  mid_o;
  logic [7:0]  high_o;
  logic [7:0]  mid_m;
  logic [7:0]  high_m;
  int          failures = 0;
  int          n_checks = 0;

  always #50 clk = ~clk;

  ebc_bus_ctrl i_dut
  (
    .clk(clk), .rstn(rstn), .cpu_req(cpu_req), .cpu_wr(cpu_wr),
    .cpu_addr(cpu_addr), .cpu_wdata(cpu_wd), .cpu_rdata(rdata),
    .cpu_done(done), .bus_width_sel(narrow), .hold_req_n(hold_n),
    .ready_n(rdy_n), .addr_low_out(a_low),
    .ad_mid_in(mid_oe ? mid_o : mid_m), .ad_mid_out(mid_o),
    .ad_mid_oe(mid_oe), .ad_high_in(high_oe ? high_o : high_m),
    .ad_high_out(high_o), .ad_high_oe(high_oe), .addr_latch_out(ale),
    .access_strobe_n(stb_n), .rw_out(rw), .byte_high_enable_n(bhe_n),
    .bus_grant_out_n(gnt_n), .sys_clk_out(sclk)
  );

  ebc_mem_model i_mem
  (
    .clk(clk), .narrow(narrow), .slow(slow), .a_low(a_low),
    .a_mid(mid_o), .a_high(high_o), .ale(ale), .strobe_n(stb_n),
    .rw(rw), .mid_drv(mid_m), .high_drv(high_m), .ready_n(rdy_n)
  );

  // ----
  // Shared tasks
  // ----
  task automatic chk(string what, logic [23:0] exp, logic [23:0] got);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One core access; pin activity is recorded while it runs.
  task automatic acc(logic wr, logic [23:0] a, logic [15:0] d,
                     output logic [15:0] q, output int n, output int sl);
    int   al;
    int   tg;
    logic ps;
    logic b;
    logic r;
    al = 0;
    tg = 0;
    n = 0;
    sl = 0;
    @(negedge clk);
    cpu_wr = wr;
    cpu_addr = a;
    cpu_wd = d;
    cpu_req = 1'b1;
    ps = sclk;
    while (done !== 1'b1 && n < 40)
    begin
      @(posedge clk);
      #1;
      n++;
      tg += (sclk !== ps);
      ps = sclk;
      al += (ale === 1'b1);
      if (stb_n === 1'b0)
      begin
        sl++;
        b = bhe_n;
        r = rw;
      end
    end
    @(negedge clk);
    chk("done pulse", 1'b1, done);
    cpu_req = 1'b0;
    q = rdata;
    chk("ale cycles", 2, al);
    chk("bhe_n", !a[0], b);
    chk("rw", !wr, r);
    chk("clock toggles", n, tg);
  endtask

  // Write then read back one address; wait states only when slow.
  task automatic pair(logic [23:0] a, logic [15:0] d);
    logic [15:0] q;
    int          n;
    int          sl;
    acc(1'b1, a, d, q, n, sl);
    acc(1'b0, a, 16'h0, q, n, sl);
    chk("read data", narrow ? {8'h00, d[7:0]} : d, q);
    chk("stretched", slow, n > 8);
    chk("strobe low", 1'b1, slow ? sl > 3 : sl == 2);
  endtask

  // ----
  // Scenarios
  // ----
  task automatic t_bus();
    pair(24'h000004, 16'hA55A);
    pair(24'h000007, 16'h1234);
    repeat (4) @(negedge clk);
    narrow = 1'b1;
    repeat (4) @(negedge clk);
    pair(24'h000003, 16'h00C3);
    pair(24'h000008, 16'h7E81);
    narrow = 1'b0;
    repeat (4) @(negedge clk);
    slow = 1'b1;
    pair(24'h00000A, 16'hBEEF);
    slow = 1'b0;
    $display("test bus done");
  endtask

  // A hold keeps the grant low and the shared pins floating.
  task automatic t_hold();
    int k;
    k = 0;
    @(negedge clk);
    hold_n = 1'b0;
    while (gnt_n !== 1'b0 && k < 12)
    begin
      @(posedge clk);
      #1;
      k++;
    end
    chk("grant float", 3'h0, {gnt_n, mid_oe, high_oe});
    repeat (10)
    begin
      @(posedge clk);
      #1;
      chk("held", 3'h0, {gnt_n, mid_oe, high_oe});
    end
    @(negedge clk);
    hold_n = 1'b1;
    @(posedge clk);
    #1;
    chk("grant kept", 1'b0, gnt_n);
    k = 0;
    while (gnt_n !== 1'b1 && k < 12)
    begin
      @(posedge clk);
      #1;
      k++;
    end
    chk("grant back", 1'b1, gnt_n);
    pair(24'h000002, 16'h0F0F);
    $display("test hold done");
  endtask

  task automatic wrap_up();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Reset for six cycles, checking idle levels while it is held.
  initial
  begin
    repeat (6) @(negedge clk);
    chk("idle", 7'h78, {rw, stb_n, bhe_n, gnt_n, ale, mid_oe, done});
    chk("rdata reset", 16'h0, rdata);
    rstn = 1'b1;
    t_bus();
    t_hold();
    wrap_up();
  end

  // The tests need some 150 cycles; cut a hang well past that.
  initial
  begin
    #200000;
    failures++;
    wrap_up();
  end
endmodule

// *** tb/ebc_mem_model.sv ***
// Partner model: a small memory on the multiplexed bus.
// Assumes the bench resolves shared pins from the design's enables.
`timescale 1ns/1ps

module ebc_mem_model
(
  input  wire logic       clk,
  input  wire logic       narrow,
  input  wire logic       slow,
  input  wire logic [7:0] a_low,
  input  wire logic [7:0] a_mid,
  input  wire logic [7:0] a_high,
  input  wire logic       ale,
  input  wire logic       strobe_n,
  input  wire logic       rw,
  output logic      [7:0] mid_drv,
  output logic      [7:0] high_drv,
  output logic            ready_n
);
  logic [3:0]  la;
  logic [15:0] mem [16];
  logic [2:0]  hc = 3'h0;
  logic [3:0]  wc = 4'hF;
  logic        drv;

  // slow wait request
  // Latch the address on ale, store writes, count wait and hold time.
  always_ff @(posedge clk)
  begin
    if (ale)
      la <= a_low[3:0];
    wc <= ale ? 4'h0 : (wc == 4'hF ? wc : wc + 4'h1);
    if (!strobe_n && !rw)
      mem[la] <= narrow ? {8'h00, a_high} : {a_mid, a_high};
    hc <= (!strobe_n && rw) ? 3'h3 : (hc == 3'h0 ? hc : hc - 3'h1);
  end

  // Read data is held past the strobe because the design samples late.
  // Released pins show inverted data, so stale values never match.
  assign drv      = (!strobe_n && rw) || hc != 3'h0;
  assign mid_drv  = drv ? mem[la][15:8] : ~mem[la][15:8];
  assign high_drv = drv ? mem[la][7:0] : ~mem[la][7:0];
  assign ready_n  = !(slow && wc < 4'h6);
endmodule
